/* rtl/pgs_pkg.sv */
package pgs_pkg;

  // Clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int DEGLITCH_US = 40;
  localparam int DEGLITCH_CYC = (DEGLITCH_US * (CLK_HZ / 1_000_000) > 0) ?
                                DEGLITCH_US * (CLK_HZ / 1_000_000) : 1;
  localparam int CNT_W = 16;
  // Edges spent in init so the role pin has crossed the synchronizer
  localparam logic [1:0] ROLE_WAIT = 2'h2;

  // Register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_STATE = 4'h8;

  // Control field positions
  localparam int CTRL_BLANK_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_DISCH_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h04;

  // Status field positions
  localparam int STAT_WARN_BIT = 0;
  localparam int STAT_SHUT_BIT = 1;

  // Role and state
  typedef enum logic [1:0] {PGS_ROLE_INIT, PGS_ROLE_PRI, PGS_ROLE_SEC}
    pgs_role_t;

  // Analog comparator and pin results
  typedef struct packed {
    logic window_fault;   // High when output out of window
    logic enable_in;      // Shared enable line level
    logic uvlo;           // Undervoltage lockout active
    logic soft_start;     // Soft start in progress
    logic hiccup;         // Hiccup protection tripped
    logic voltage_transition;
    logic temp_above_warn;  // Above 150 C
    logic temp_below_130;   // Below 130 C
    logic temp_above_shut;  // Above 170 C
    logic temp_below_150;   // Below 150 C
    logic power_good_line;  // Level of shared power-good wire
    logic chain_out_low;    // Resistor to ground on clock-chain out
  } pgs_sense_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pgs_bus_t;

  typedef struct packed {
    logic pg_o;
    logic pg_oe;
    logic en_o;
    logic en_oe;
    logic output_discharge;
    logic switch_stop;
    logic restart_soft_start;
    logic force_dcm;
  } pgs_pins_t;

endpackage : pgs_pkg

/* rtl/pgs_supervisor.sv */
`timescale 1ns/100ps
// Contract
// - Standalone or primary drives open-drain power-good
// - Secondary treats power-good line as input
// - Release power-good only when fully good; a secondary releases when its pulldown latch clears
// - Force low on shutdown, disable, UVLO, soft-start
// - Window fault outside 95 to 105 percent
// - Deglitch window result about 40 us
// - Blanking bit ignores window during transition
// - No blanking: fault during transition pulls low; a secondary ignores the window fault
// - Secondary init sets hold and pulldown latches
// - Secondary soft-start done clears pulldown latch
// - Line high clears hold latch, go continuous
// - Above 150 C set warning flag
// - Read clears warning only below 130 C
// - Above 170 C stop, flag, power-good low
// - Shutdown pulls enable low if single bit 0
// - Shutdown discharges output if discharge bit 1
// - Cooled below 150 C restart, release pins
// - Read clears shutdown flag only below 150 C
// - Shutdown with single bit 0 disables stack, auto restart
// - Hiccup pulls power-good low until regulating; a secondary ignores hiccup
// - Role from clock-chain output at init
module pgs_supervisor
  import pgs_pkg::*;
#(
  parameter int DEGLITCH = DEGLITCH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Analog and pin inputs
  input wire pgs_pkg::pgs_sense_t sense,
  // Register port
  input wire pgs_pkg::pgs_bus_t bus,
  output logic [7:0] rdata,
  // Pin and converter controls
  output pgs_pkg::pgs_pins_t pins
);
  import pgs_pkg::*;

  // The filter counter must be able to reach the filter length
  if (DEGLITCH < 1 || DEGLITCH >= (1 << CNT_W)) begin : g_bad_deglitch
    $error("DEGLITCH out of range");
  end

  localparam logic [CNT_W-1:0] DG_MAX = CNT_W'(DEGLITCH);

  typedef struct packed {
    pgs_sense_t s1;
    pgs_sense_t s2;
    pgs_role_t role;
    logic [1:0] init_cnt;
    logic [CNT_W-1:0] dg_cnt;
    logic dg_fault;
    logic [7:0] ctrl;
    logic warn;
    logic shut;
    logic in_shut;
    logic ccm_hold_latch;
    logic pulldown_latch;
    logic [7:0] rdata;
    pgs_pins_t pins;
  } pgs_state_t;

  pgs_state_t q, d;
  pgs_sense_t s;
  logic raw_fault;
  logic good;
  logic shut_now;

  assign rdata = q.rdata;
  assign pins = q.pins;

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    s = q.s2;
    // Two-stage sync; only the second stage is read below
    d.s1 = sense;
    d.s2 = q.s1;
    d.rdata = 8'h00;

    // Role taken once after reset from the chain pin; the sync stages
    // still hold their reset zeros at first, so wait for real levels
    if (q.role == PGS_ROLE_INIT) begin
      d.ccm_hold_latch = 1'b1;
      d.pulldown_latch = 1'b1;
      if (q.init_cnt == ROLE_WAIT) begin
        d.role = s.chain_out_low ? PGS_ROLE_SEC : PGS_ROLE_PRI;
      end else begin
        d.init_cnt = q.init_cnt + 2'h1;
      end
    end

    // Window result, blanked during ramps when selected
    raw_fault = s.window_fault;
    if (q.ctrl[CTRL_BLANK_BIT] && s.voltage_transition) begin
      raw_fault = 1'b0;
    end // otherwise the fault passes unchanged

    // Deglitch: fault must hold steady DEGLITCH cycles to change
    if (raw_fault == q.dg_fault) begin
      d.dg_cnt = '0;
    end else if (q.dg_cnt >= DG_MAX - 1'b1) begin
      d.dg_cnt = '0;
      d.dg_fault = raw_fault;
    end else begin
      d.dg_cnt = q.dg_cnt + 1'b1;
    end

    // Thermal shutdown with hysteresis
    shut_now = q.in_shut;
    if (s.temp_above_shut) begin
      shut_now = 1'b1;
    end else if (s.temp_below_150) begin
      shut_now = 1'b0;
    end
    d.in_shut = shut_now;

    // Sticky flags: read clears only on release, set wins
    if (bus.rd && bus.addr == ADDR_STATUS) begin
      d.rdata[STAT_WARN_BIT] = q.warn;
      d.rdata[STAT_SHUT_BIT] = q.shut;
      if (s.temp_below_130) begin
        d.warn = 1'b0;
      end
      if (s.temp_below_150) begin
        d.shut = 1'b0;
      end
    end
    if (s.temp_above_warn) begin
      d.warn = 1'b1;
    end
    if (s.temp_above_shut) begin
      d.shut = 1'b1;
    end

    // Other reads and control writes
    if (bus.rd && bus.addr == ADDR_CTRL) begin
      d.rdata = q.ctrl;
    end
    if (bus.rd && bus.addr == ADDR_STATE) begin
      d.rdata = {3'h0, q.in_shut, q.dg_fault, q.ccm_hold_latch,
                 q.pulldown_latch, q.role == PGS_ROLE_SEC};
    end
    if (bus.wr && bus.addr == ADDR_CTRL) begin
      d.ctrl = {5'h00, bus.wdata[2:0]};
    end

    // Secondary latches
    if (q.role == PGS_ROLE_SEC) begin
      if (!s.soft_start && !shut_now && s.enable_in) begin
        d.pulldown_latch = 1'b0;
      end
      if (!q.pulldown_latch && s.power_good_line) begin
        d.ccm_hold_latch = 1'b0;
      end
      if (shut_now || !s.enable_in || s.uvlo) begin
        d.pulldown_latch = 1'b1; // Re-arm for the next start
        d.ccm_hold_latch = 1'b1;
      end
    end

    // Power-good qualification for primary or standalone
    good = s.enable_in && !s.uvlo && !s.soft_start && !shut_now &&
           !s.hiccup && !q.dg_fault;
    d.pins.pg_o = 1'b0;
    case (q.role)
      PGS_ROLE_PRI: d.pins.pg_oe = !good;
      PGS_ROLE_SEC: d.pins.pg_oe = q.pulldown_latch;
      default: d.pins.pg_oe = 1'b1;
    endcase
    // Only a secondary is held in DCM, so a primary never shows a pulse
    d.pins.force_dcm = q.role == PGS_ROLE_SEC && q.ccm_hold_latch;

    // Shutdown actions on the pins and converter
    d.pins.en_o = 1'b0;
    d.pins.en_oe = shut_now && !q.ctrl[CTRL_SINGLE_BIT];
    d.pins.switch_stop = shut_now;
    d.pins.output_discharge = shut_now &&
                              q.ctrl[CTRL_DISCH_BIT];
    d.pins.restart_soft_start = q.in_shut && !shut_now;
  end

  // Single state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.role <= PGS_ROLE_INIT;
      q.pins.pg_oe <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule : pgs_supervisor

/* bench/pgs_stack_model.sv */
`timescale 1ns/100ps
module pgs_stack_model
  import pgs_pkg::*;
(
  // Design drive
  input wire pgs_pkg::pgs_pins_t pins,
  // Peers pulling low
  input wire logic peer_en_low,
  input wire logic peer_pg_low,
  // Wire levels
  output logic en_lvl,
  output logic pg_lvl
);
  // Pulled-up shared wires; one hot peer holds the stack off
  assign en_lvl = !(pins.en_oe || peer_en_low);
  assign pg_lvl = !(pins.pg_oe || peer_pg_low);
endmodule : pgs_stack_model

/* bench/pgs_supervisor_asserts.sv */
`timescale 1ns/100ps
module pgs_checker
  import pgs_pkg::*;
#(parameter int DEGLITCH = DEGLITCH_CYC) (
  // Watched ports
  input wire logic clk,
  input wire logic reset,
  input wire pgs_pkg::pgs_sense_t sense,
  input wire pgs_pkg::pgs_bus_t bus,
  input wire logic [7:0] rdata,
  input wire pgs_pkg::pgs_pins_t pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Five cycles covers the synchronizer and output flop
  sequence s_hot;
    sense.temp_above_shut [*5];
  endsequence
  a_uvlo_low: assert property (sense.uvlo [*5] |=> pins.pg_oe)
    else $error("pg free in lockout");
  a_dis_low: assert property ((!sense.enable_in) [*5] |=> pins.pg_oe)
    else $error("pg free when off");
  a_hot_pg_low: assert property (s_hot |=> pins.pg_oe)
    else $error("pg free when hot");
  a_hot_stop: assert property (s_hot |=> pins.switch_stop)
    else $error("no stop when hot");
  a_hiccup_low: assert property (sense.hiccup [*5] |=> pins.pg_oe)
    else $error("pg free in hiccup");
  a_cool_restart: assert property ($fell(pins.switch_stop) |->
    $past(sense.temp_below_150, 3)) else $error("early restart");
  a_release_good: assert property ($fell(pins.pg_oe) |->
    $past(sense.enable_in, 3) && !$past(sense.temp_above_shut, 3))
    else $error("bad pg release");
  a_restart_pulse: assert property (pins.restart_soft_start |=>
    !pins.restart_soft_start) else $error("restart not one cycle");
  a_ccm_late: assert property ($fell(pins.force_dcm) |->
    $past(sense.power_good_line, 4)) else $error("early ccm");
endmodule : pgs_checker
bind pgs_supervisor pgs_checker #(.DEGLITCH(DEGLITCH)) pgs_checker_inst (
  .clk(clk), .reset(reset), .sense(sense), .bus(bus), .rdata(rdata),
  .pins(pins));

/* bench/power_good_thermal_supervisor_tb_top.sv */
`timescale 1ns/100ps
module power_good_thermal_supervisor_tb_top;
  import pgs_pkg::*;
  logic clk, reset, peer_en_low, peer_pg_low, en_lvl, pg_lvl;
  pgs_sense_t s, sense;
  pgs_bus_t bus;
  pgs_pins_t pins;
  logic [7:0] rdata;
  int n_fail, cmp_count, cyc;
  pgs_supervisor #(.DEGLITCH(8)) pgs_supervisor_inst (.clk(clk),
    .reset(reset), .sense(sense), .bus(bus), .rdata(rdata), .pins(pins));
  pgs_stack_model pgs_stack_model_inst (.pins(pins), .en_lvl(en_lvl),
    .peer_en_low(peer_en_low), .peer_pg_low(peer_pg_low), .pg_lvl(pg_lvl));
  // Shared wire levels come from the stack model
  always_comb begin
    sense = s;
    sense.enable_in = en_lvl;
    sense.power_good_line = pg_lvl;
  end
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pc(input logic [7:0] m, input logic [7:0] e);
    chk(pins & m, e);
  endtask : pc
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1;
    chk(rdata, e);
  endtask : rd
  task automatic end_sim();
    $display("checks %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    reset = 1'b1;
    bus = '0;
    {peer_en_low, peer_pg_low} = 2'b00;
    s = '0;
    {s.temp_below_130, s.temp_below_150} = 2'b11;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    wt(20);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(4'hc, 8'h00);
    rd(ADDR_STATE, 8'h06);
    pc(8'hfd, 8'h00);
    $display("test 1 done");
    // A glitch shorter than the filter must not reach the pin
    @(posedge clk) s.window_fault <= 1'b1;
    wt(5);
    @(posedge clk) s.window_fault <= 1'b0;
    wt(12);
    pc(8'h40, 8'h00);
    @(posedge clk) s.window_fault <= 1'b1;
    wt(16);
    pc(8'h40, 8'h40);
    @(posedge clk) s.voltage_transition <= 1'b1;
    wr(ADDR_CTRL, 8'h05);
    wt(20);
    pc(8'h40, 8'h00);
    wr(ADDR_CTRL, 8'h04);
    wt(20);
    pc(8'h40, 8'h40);
    @(posedge clk) {s.window_fault, s.voltage_transition} <= 2'b00;
    wt(24);
    $display("test 2 done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {s.uvlo, s.soft_start, s.hiccup,
                      peer_en_low} <= 4'h8 >> i;
      wt(8);
      pc(8'h40, 8'h40);
      @(posedge clk) {s.uvlo, s.soft_start, s.hiccup, peer_en_low} <= 4'h0;
      wt(24);
      pc(8'h40, 8'h00);
    end
    $display("test 3 done");
    @(posedge clk) {s.temp_above_warn, s.temp_below_130} <= 2'b10;
    wt(6);
    rd(ADDR_STATUS, 8'h01);
    @(posedge clk) s.temp_above_warn <= 1'b0;
    wt(6);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h01);
    @(posedge clk) s.temp_below_130 <= 1'b1;
    wt(6);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h00);
    // Set and release together: the set must win over the read clear
    @(posedge clk) s.temp_above_warn <= 1'b1;
    wt(6);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h01);
    @(posedge clk) s.temp_above_warn <= 1'b0;
    wt(6);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'h00);
    $display("test 4 done");
    @(posedge clk) {s.temp_above_shut, s.temp_below_150} <= 2'b10;
    wt(8);
    pc(8'hfd, 8'h5c);
    rd(ADDR_STATUS, 8'h02);
    rd(ADDR_STATUS, 8'h02);
    // Restart pulse stands exactly one cycle, three edges after cooling
    @(posedge clk) {s.temp_above_shut, s.temp_below_150} <= 2'b01;
    wt(3);
    pc(8'h16, 8'h02);
    wt(1);
    pc(8'h16, 8'h00);
    rd(ADDR_STATUS, 8'h02);
    rd(ADDR_STATUS, 8'h00);
    wt(24);
    pc(8'h40, 8'h00);
    // Single bit set, discharge off: stop, flag and pg low only; upper bits drop
    wr(ADDR_CTRL, 8'hfa);
    rd(ADDR_CTRL, 8'h02);
    @(posedge clk) {s.temp_above_shut, s.temp_below_150} <= 2'b10;
    wt(8);
    pc(8'hfd, 8'h44);
    @(posedge clk) {s.temp_above_shut, s.temp_below_150} <= 2'b01;
    wt(24);
    pc(8'h5d, 8'h00);
    rd(ADDR_STATUS, 8'h02);
    wr(ADDR_CTRL, CTRL_RESET);
    $display("test 5 done");
    @(posedge clk) reset <= 1'b1;
    {s.chain_out_low, s.soft_start, peer_pg_low} <= 3'b111;
    wt(3);
    @(posedge clk) reset <= 1'b0;
    wt(10);
    pc(8'h41, 8'h41);
    rd(ADDR_STATE, 8'h07);
    @(posedge clk) s.soft_start <= 1'b0;
    wt(10);
    pc(8'h41, 8'h01);
    @(posedge clk) peer_pg_low <= 1'b0;
    wt(10);
    pc(8'h41, 8'h00);
    rd(ADDR_STATE, 8'h01);
    $display("test 6 done");
    end_sim();
  end
endmodule : power_good_thermal_supervisor_tb_top
